//--- logic/afc_pkg.sv
// Shared constants and types for the asynchronous flash command/status host controller.
// Assumes a 20 MHz ref_clk and an AXI4-Lite master with 32-bit data on the register side.
package afc_pkg;

	// ****************************************************************
	// Register map, byte addresses
	// ****************************************************************
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_CMD = 5'h04;
	localparam logic [4:0] OFS_ADDR = 5'h08;
	localparam logic [4:0] OFS_WDATA = 5'h0C;
	localparam logic [4:0] OFS_RDATA = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h14;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_PDOWN = 0;
	localparam int CTRL_X16 = 1;
	localparam int CTRL_PULSE = 2;
	localparam int CTRL_DENS = 3;
	localparam int CTRL_SEL_ON = 5;
	localparam int CTRL_SEL_OFF = 8;
	localparam int CMD_WRITE = 0;
	localparam int CMD_SUSP = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_STS = 1;
	localparam int STAT_SR7 = 2;
	localparam int STAT_RD_OK = 3;
	localparam int STAT_WR_OK = 4;
	localparam int STAT_PULSE_EV = 5;
	localparam int STAT_REFUSED = 6;

	// ****************************************************************
	// Reset values, address masks and AXI response codes
	// ****************************************************************
	localparam logic [2:0] SEL_ON_RST = 3'h0;
	localparam logic [2:0] SEL_OFF_RST = 3'h7;
	localparam logic [23:0] MASK_32M = 24'h3F_FFFF;
	localparam logic [23:0] MASK_64M = 24'h7F_FFFF;
	localparam logic [23:0] MASK_128M = 24'hFF_FFFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_PHQV_NS = 1000;
	localparam int T_PHWL_NS = 1000;
	localparam int T_WP_NS = 100;
	localparam int T_ACC_NS = 150;
	localparam int SYNC_CYC = 2;
	localparam logic [7:0] PHQV_CYC = 8'((T_PHQV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] PHWL_CYC = 8'((T_PHWL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC);

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SETUP = 4'b0010,
		ST_STROBE = 4'b0100,
		ST_HOLD = 4'b1000
	} afc_st_e;

	typedef struct packed {
		logic aw_have;
		logic [4:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata_bus;
		logic pdown;
		logic x16;
		logic pulse;
		logic [1:0] dens;
		logic [2:0] sel_on;
		logic [2:0] sel_off;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic wr;
		logic susp;
		afc_st_e st;
		logic [7:0] cnt;
		logic [7:0] wake_cnt;
		logic sts_m;
		logic sts_s;
		logic sts_p;
		logic [15:0] dq_m;
		logic [15:0] dq_s;
		logic ev_pulse;
		logic ev_refused;
		logic [23:0] f_addr;
		logic [15:0] f_dq_o;
		logic [1:0] f_dq_oe;
		logic [2:0] f_ce;
		logic f_oe_n;
		logic f_we_n;
		logic f_rp_n;
		logic f_byte_n;
	} afc_state_s;

endpackage

//--- logic/afc_host_ctrl.sv
// Host-side controller that runs single read and write cycles on an asynchronous NOR flash.
// Assumes software on AXI4-Lite, flash pins wired directly, open-drain status pulled up outside.
`timescale 1ns/1ns
module afc_host_ctrl
	import afc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_awaddr,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Flash pins
	output logic [23:0] word_address_inputs,
	input wire logic [15:0] data_lane_i,
	output logic [15:0] data_lane_o,
	output logic [1:0] data_lane_oe,
	output logic chip_select_0,
	output logic chip_select_1,
	output logic chip_select_2,
	output logic output_enable_n,
	output logic write_enable_n,
	output logic reset_powerdown_n,
	output logic width_select_n,
	input wire logic status_output_pin
);

	afc_state_s q;
	afc_state_s d;
	logic rd_ok;
	logic wr_ok;
	logic dev_busy;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [23:0] pin_addr(input logic [23:0] a, input logic x16,
		input logic [1:0] dens);
		logic [23:0] m;
		logic [23:0] p;
		unique case (dens)
			2'd0: m = MASK_32M;
			2'd1: m = MASK_64M;
			default: m = MASK_128M;
		endcase
		// Word mode shifts the word index up one place and leaves the byte select low
		p = x16 ? {a[22:0], 1'b0} : a;
		return p & m;
	endfunction

	assign rd_ok = q.wake_cnt >= PHQV_CYC;
	assign wr_ok = q.wake_cnt >= PHWL_CYC;
	// In pulse mode the pin no longer shows busy, so software must poll bit 7 itself
	assign dev_busy = !q.pulse && !q.sts_s;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [31:0] cur;
		logic [31:0] nw;
		logic launch;
		logic refuse;
		cur = 32'h0000_0000;
		nw = 32'h0000_0000;
		launch = 1'b0;
		refuse = 1'b0;
		d = q;
		// Pin inputs pass two flops before anything looks at them
		d.sts_m = status_output_pin;
		d.sts_s = q.sts_m;
		d.sts_p = q.sts_s;
		d.dq_m = data_lane_i;
		d.dq_s = q.dq_m;
		if (!q.f_rp_n) begin
			d.wake_cnt = 8'h00;
		end else if (q.wake_cnt != 8'hFF) begin
			d.wake_cnt = q.wake_cnt + 8'h01;
		end

		// AXI write channel
		if (s_axi_bready && q.bvalid) begin
			d.bvalid = 1'b0;
		end
		if (s_axi_awvalid && !q.aw_have && !q.bvalid) begin
			d.aw_have = 1'b1;
			d.aw_addr = s_axi_awaddr[4:0];
		end
		if (s_axi_wvalid && !q.w_have && !q.bvalid) begin
			d.w_have = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.aw_have && q.w_have && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			unique case (q.aw_addr)
				OFS_CTRL: begin
					cur = {21'h00_0000, q.sel_off, q.sel_on, q.dens, q.pulse, q.x16, q.pdown};
					nw = merge(cur, q.w_data, q.w_strb);
					d.pdown = nw[CTRL_PDOWN];
					d.x16 = nw[CTRL_X16];
					d.pulse = nw[CTRL_PULSE];
					d.dens = nw[CTRL_DENS +: 2];
					d.sel_on = nw[CTRL_SEL_ON +: 3];
					d.sel_off = nw[CTRL_SEL_OFF +: 3];
				end
				OFS_ADDR: begin
					nw = merge({8'h00, q.addr}, q.w_data, q.w_strb);
					d.addr = nw[23:0];
				end
				OFS_WDATA: begin
					nw = merge({16'h0000, q.wdata}, q.w_data, q.w_strb);
					d.wdata = nw[15:0];
				end
				OFS_CMD: begin
					// Refuse cycles that the flash could not take safely
					refuse = q.st != ST_IDLE || q.pdown || !q.f_rp_n ||
						(q.w_data[CMD_WRITE] ? !wr_ok : !rd_ok) ||
						(q.w_data[CMD_WRITE] && !q.w_data[CMD_SUSP] && dev_busy);
					launch = !refuse;
					d.wr = q.w_data[CMD_WRITE];
					d.susp = q.w_data[CMD_SUSP];
				end
				OFS_STATUS: begin
					if (q.w_strb[0] && q.w_data[STAT_PULSE_EV]) begin
						d.ev_pulse = 1'b0;
					end
					if (q.w_strb[0] && q.w_data[STAT_REFUSED]) begin
						d.ev_refused = 1'b0;
					end
				end
				OFS_RDATA: begin
				end
				default: d.bresp = RESP_SLVERR;
			endcase
		end

		// AXI read channel
		if (s_axi_rready && q.rvalid) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			unique case (s_axi_araddr[4:0])
				OFS_CTRL: d.rdata_bus = {21'h00_0000, q.sel_off, q.sel_on, q.dens, q.pulse,
					q.x16, q.pdown};
				OFS_ADDR: d.rdata_bus = {8'h00, q.addr};
				OFS_WDATA: d.rdata_bus = {16'h0000, q.wdata};
				OFS_RDATA: d.rdata_bus = {16'h0000, q.rdata};
				OFS_STATUS: d.rdata_bus = {25'h000_0000, q.ev_refused, q.ev_pulse, wr_ok, rd_ok,
					q.rdata[7], q.sts_s, q.st != ST_IDLE};
				OFS_CMD: d.rdata_bus = 32'h0000_0000;
				default: begin
					d.rdata_bus = 32'h0000_0000;
					d.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Flash cycle sequencer
		unique case (q.st)
			ST_IDLE: begin
				d.f_ce = q.sel_off;
				d.f_oe_n = 1'b1;
				d.f_we_n = 1'b1;
				d.f_dq_oe = 2'b00;
				d.f_rp_n = !q.pdown;
				d.f_byte_n = q.x16;
				if (launch) begin
					d.f_addr = pin_addr(q.addr, q.x16, q.dens);
					d.f_ce = q.sel_on;
					if (q.w_data[CMD_WRITE]) begin
						// Word mode drives both lanes, byte mode only the low one
						d.f_dq_o = q.x16 ? q.wdata : {8'h00, q.wdata[7:0]};
						d.f_dq_oe = q.x16 ? 2'b11 : 2'b01;
					end else begin
						d.f_oe_n = 1'b0;
					end
					d.st = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (q.wr) begin
					d.f_we_n = 1'b0;
					d.cnt = WP_CYC - 8'h01;
				end else begin
					d.cnt = ACC_CYC - 8'h01;
				end
				d.st = ST_STROBE;
			end
			ST_STROBE: begin
				if (q.cnt != 8'h00) begin
					d.cnt = q.cnt - 8'h01;
				end else begin
					if (q.wr) begin
						// Address and data stay put one more cycle past this rising edge
						d.f_we_n = 1'b1;
					end else begin
						d.rdata = q.x16 ? q.dq_s : {8'h00, q.dq_s[7:0]};
						d.f_oe_n = 1'b1;
					end
					d.st = ST_HOLD;
				end
			end
			ST_HOLD: begin
				d.f_ce = q.sel_off;
				d.f_dq_oe = 2'b00;
				d.st = ST_IDLE;
			end
			default: d.st = ST_IDLE;
		endcase

		// Sticky events; a new event beats a clear in the same cycle
		if (q.pulse && q.sts_s && !q.sts_p) begin
			d.ev_pulse = 1'b1;
		end
		if (refuse) begin
			d.ev_refused = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			q <= '0;
			q.sel_on <= SEL_ON_RST;
			q.sel_off <= SEL_OFF_RST;
			q.st <= ST_IDLE;
			q.sts_m <= 1'b1;
			q.sts_s <= 1'b1;
			q.sts_p <= 1'b1;
			q.f_ce <= SEL_OFF_RST;
			q.f_oe_n <= 1'b1;
			q.f_we_n <= 1'b1;
			q.f_rp_n <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign s_axi_awready = !q.aw_have && !q.bvalid;
	assign s_axi_wready = !q.w_have && !q.bvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata_bus;
	assign s_axi_rresp = q.rresp;
	assign word_address_inputs = q.f_addr;
	assign data_lane_o = q.f_dq_o;
	assign data_lane_oe = q.f_dq_oe;
	assign chip_select_0 = q.f_ce[0];
	assign chip_select_1 = q.f_ce[1];
	assign chip_select_2 = q.f_ce[2];
	assign output_enable_n = q.f_oe_n;
	assign write_enable_n = q.f_we_n;
	assign reset_powerdown_n = q.f_rp_n;
	assign width_select_n = q.f_byte_n;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	// Data and select stand through the first sample after the strobe rises, address one more
	property p_we_hold;
		$rose(write_enable_n) |-> $stable(word_address_inputs) && $stable(data_lane_o) &&
			data_lane_oe != 2'b00 && {chip_select_2, chip_select_1, chip_select_0} == q.sel_on
			##1 $stable(word_address_inputs);
	endproperty
	a_we_hold: assert property (p_we_hold) else $error("write data moved at strobe end");

	property p_no_contention;
		!output_enable_n |-> data_lane_oe == 2'b00;
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("bus driven during read");

	property p_byte_lane;
		!width_select_n |-> !data_lane_oe[1];
	endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("high lane driven in byte mode");

	property p_word_a0;
		(width_select_n && !chip_select_0 == !q.sel_on[0] && q.st != ST_IDLE) |->
			!word_address_inputs[0];
	endproperty
	a_word_a0: assert property (p_word_a0) else $error("byte select set in word mode");

	property p_wake;
		$fell(write_enable_n) |-> q.wake_cnt >= PHWL_CYC && reset_powerdown_n;
	endproperty
	a_wake: assert property (p_wake) else $error("write before wake time");

	property p_pdown;
		!reset_powerdown_n |-> write_enable_n && output_enable_n;
	endproperty
	a_pdown: assert property (p_pdown) else $error("access during power-down");

	property p_strobe;
		$fell(write_enable_n) |-> !write_enable_n [*2] ##1 write_enable_n;
	endproperty
	a_strobe: assert property (p_strobe) else $error("write strobe length wrong");

	property p_busy_guard;
		(q.st == ST_SETUP && $past(q.st) == ST_IDLE && q.wr && !q.susp && !q.pulse) |->
			$past(q.sts_s);
	endproperty
	a_busy_guard: assert property (p_busy_guard) else $error("write issued while busy");

	property p_select;
		!write_enable_n |-> {chip_select_2, chip_select_1, chip_select_0} == q.sel_on;
	endproperty
	a_select: assert property (p_select) else $error("strobe outside selection");

	c_write: cover property ($rose(write_enable_n));
	c_read: cover property ($rose(output_enable_n) ##2 q.st == ST_IDLE);
	c_pulse: cover property ($rose(q.ev_pulse));

endmodule // afc_host_ctrl

//--- testbench/afc_flash_model.sv
// Behavioural flash device seen from the host controller's pins.
// Assumes the bench resolves the shared data pins and the pulled-up status line.
`timescale 1ns/1ns
module afc_flash_model #(
	parameter logic [7:0] CMD_RD = 8'hFF, CMD_ST = 8'h70, CMD_PG = 8'h40,
	parameter int BUSY_NS = 2000
) (
	// Pins
	input wire logic [23:0] addr,
	input wire logic [15:0] din,
	output logic [15:0] dout,
	input wire logic [2:0] cs,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic rp_n,
	input wire logic byte_n,
	output logic sts_low
);
	logic [15:0] mem [0:255];
	logic [15:0] flt = 16'h5A5A;
	logic [15:0] rd;
	logic st_mode, busy, pend;
	wire sel = (cs == 3'h0);
	// Released lines keep changing so stale values never look valid
	always #25 flt = ~flt;
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	always @(posedge busy) #BUSY_NS busy <= 1'b0;
	always @(posedge we_n or negedge rp_n) begin
		if (!rp_n) begin
			busy <= 1'b0;
			st_mode <= 1'b0;
			pend <= 1'b0;
		end else if (sel && !busy) begin
			if (pend) begin
				if (byte_n) mem[addr[8:1]] <= din;
				else if (addr[0]) mem[addr[8:1]][15:8] <= din[7:0];
				else mem[addr[8:1]][7:0] <= din[7:0];
				pend <= 1'b0;
				busy <= 1'b1;
				st_mode <= 1'b1;
			end else if (din[7:0] == CMD_PG) pend <= 1'b1;
			else if (din[7:0] == CMD_ST) st_mode <= 1'b1;
			else if (din[7:0] == CMD_RD) st_mode <= 1'b0;
		end
	end
	always_comb begin
		rd = mem[addr[8:1]];
		if (!byte_n) rd = {flt[15:8], addr[0] ? rd[15:8] : rd[7:0]};
		if (st_mode) rd = {flt[15:8], !busy, busy ? flt[6:0] : 7'h00};
		dout = (sel && !oe_n && rp_n) ? rd : flt;
		sts_low = busy && rp_n;
	end
endmodule // afc_flash_model

//--- testbench/tb.sv
// Self-checking bench: AXI4-Lite register tasks drive the controller against a flash model.
// Assumes default chip-select patterns and the package timing constants.
`timescale 1ns/1ns
module tb
	import afc_pkg::*;
;
	logic ref_clk = 0, nrst = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, v;
	logic [1:0] bresp, rresp, rr, dl_oe;
	logic [15:0] dl_o, dl_i, fdq;
	logic [23:0] fa;
	logic awr, wr_r, bv, arr, rv, cs0, cs1, cs2, oen, wen, rpn, wsn, stsl;
	int bad_count = 0, total_checks = 0;
	assign dl_i = {dl_oe[1] ? dl_o[15:8] : fdq[15:8], dl_oe[0] ? dl_o[7:0] : fdq[7:0]};
	always #25 ref_clk = ~ref_clk;
	afc_host_ctrl DUT (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_awaddr(awaddr), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(brdy),
		.s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(araddr),
		.s_axi_rvalid(rv), .s_axi_rready(rrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.word_address_inputs(fa), .data_lane_i(dl_i), .data_lane_o(dl_o),
		.data_lane_oe(dl_oe), .chip_select_0(cs0), .chip_select_1(cs1), .chip_select_2(cs2),
		.output_enable_n(oen), .write_enable_n(wen), .reset_powerdown_n(rpn),
		.width_select_n(wsn), .status_output_pin(~stsl));
	afc_flash_model flash (.addr(fa), .din(dl_o), .dout(fdq), .cs({cs2, cs1, cs0}),
		.oe_n(oen), .we_n(wen), .rp_n(rpn), .byte_n(wsn), .sts_low(stsl));

	// ****************************************************************
	// Bus tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic ta, tw, tb_;
		@(posedge ref_clk);
		awaddr <= {27'h0, a};
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		ta = 0;
		tw = 0;
		tb_ = 0;
		while (!tb_) begin
			@(negedge ref_clk);
			ta = ta | (awv & awr);
			tw = tw | (wv & wr_r);
			tb_ = (bv === 1'b1);
			@(posedge ref_clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (tb_) brdy <= 1'b0;
		end
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge ref_clk);
		araddr <= {27'h0, a};
		arv <= 1'b1;
		rrdy <= 1'b1;
		ta = 0;
		tr = 0;
		while (!tr) begin
			@(negedge ref_clk);
			ta = ta | (arv & arr);
			tr = (rv === 1'b1);
			d = rdata;
			r = rresp;
			@(posedge ref_clk);
			if (ta) arv <= 1'b0;
			if (tr) rrdy <= 1'b0;
		end
	endtask
	// One flash cycle, then wait for the sequencer to go idle
	task automatic fc(input logic w, input logic [23:0] a, input logic [15:0] d);
		wr(OFS_ADDR, {8'h0, a});
		wr(OFS_WDATA, {16'h0, d});
		wr(OFS_CMD, {31'h0, w});
		repeat (40) begin
			rd(OFS_STATUS, v, rr);
			if (v[STAT_BUSY] === 1'b0) break;
		end
		chk({31'h0, v[STAT_BUSY]}, 32'h0);
	endtask
	task automatic rd_bit(input int b, input logic e);
		rd(OFS_STATUS, v, rr);
		chk({31'h0, v[b]}, {31'h0, e});
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		wr(OFS_CMD, 32'h0000_0001);
		rd_bit(STAT_REFUSED, 1'b1);
		rd(OFS_CTRL, v, rr);
		chk(v, 32'h0000_0700);
		rd(5'h18, v, rr);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
		chk({29'h0, cs2, cs1, cs0}, 32'h0000_0007);
		wr(OFS_STATUS, 32'h0000_0060);
		repeat (25) @(posedge ref_clk);
		$display("test defaults done");
		fc(1'b1, 24'h10, 16'h0040);
		fc(1'b1, 24'h10, 16'h003C);
		rd_bit(STAT_STS, 1'b0);
		wr(OFS_CMD, 32'h0000_0001);
		rd_bit(STAT_REFUSED, 1'b1);
		repeat (100) begin
			rd(OFS_STATUS, v, rr);
			if (v[STAT_STS] === 1'b1) break;
		end
		chk({31'h0, v[STAT_STS]}, 32'h1);
		fc(1'b1, 24'h0, 16'h0070);
		fc(1'b0, 24'h10, 16'h0);
		rd_bit(STAT_SR7, 1'b1);
		rd(OFS_RDATA, v, rr);
		chk(v, 32'h0000_0080);
		fc(1'b1, 24'h0, 16'h00FF);
		fc(1'b0, 24'h10, 16'h0);
		rd(OFS_RDATA, v, rr);
		chk(v, 32'h0000_003C);
		fc(1'b0, 24'h11, 16'h0);
		rd(OFS_RDATA, v, rr);
		chk(v, 32'h0000_00FF);
		$display("test byte mode done");
		wr(OFS_CTRL, 32'h0000_0702);
		// Pins follow the control word one edge after the write response
		@(negedge ref_clk);
		chk({31'h0, wsn}, 32'h1);
		fc(1'b1, 24'h9, 16'h0040);
		fc(1'b1, 24'h9, 16'hBEEF);
		repeat (60) @(posedge ref_clk);
		fc(1'b1, 24'h0, 16'h00FF);
		fc(1'b0, 24'h9, 16'h0);
		rd(OFS_RDATA, v, rr);
		chk(v, 32'h0000_BEEF);
		$display("test word mode done");
		fc(1'b1, 24'h0, 16'h0070);
		wr(OFS_STATUS, 32'h0000_0060);
		wr(OFS_CTRL, 32'h0000_0703);
		@(negedge ref_clk);
		chk({31'h0, rpn}, 32'h0);
		wr(OFS_CMD, 32'h0000_0001);
		rd_bit(STAT_REFUSED, 1'b1);
		wr(OFS_CTRL, 32'h0000_0702);
		repeat (25) @(posedge ref_clk);
		fc(1'b0, 24'h9, 16'h0);
		rd(OFS_RDATA, v, rr);
		chk(v, 32'h0000_BEEF);
		$display("test power-down done");
		wr(OFS_CTRL, 32'h0000_0706);
		fc(1'b1, 24'h4, 16'h0040);
		fc(1'b1, 24'h4, 16'h1234);
		repeat (60) @(posedge ref_clk);
		rd_bit(STAT_PULSE_EV, 1'b1);
		wr(OFS_STATUS, 32'h0000_0020);
		rd_bit(STAT_PULSE_EV, 1'b0);
		fc(1'b1, 24'h0, 16'h00FF);
		fc(1'b0, 24'h4, 16'h0);
		rd(OFS_RDATA, v, rr);
		chk(v, 32'h0000_1234);
		chk({8'h0, fa}, 32'h0000_0008);
		fc(1'b0, 24'hFF_FFFF, 16'h0);
		chk({8'h0, fa}, 32'h003F_FFFE);
		wr(OFS_CTRL, 32'h0000_0712);
		fc(1'b0, 24'hFF_FFFF, 16'h0);
		chk({8'h0, fa}, 32'h00FF_FFFE);
		$display("test pulse and density done");
		print_verdict;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		print_verdict;
	end
endmodule // tb
